/* File: ucc_pkg.sv */
// package: constants and types for the usb conditioner config/control block
// assumes a 100 MHz system clock, synchronous active-high reset
// Functional notes
// [R1] full speed: no compensation, detect high
// [R2] high speed: compensate with set gains, detect high
// [R3] reset pin low: shutdown, no compensation, detect low
// [R4] shutdown leaves usb data path untouched
// [R5] i2c target at 100 kHz bus rate
// [R6] i2c enabled only if scl, sda high after reset
// [R7] respond at fixed seven-bit target address
// [R8] controller pulses hold bit after gain change
// [R9] controller keeps reserved fields at default
// [R10] controller uses read-modify-write on registers
// [R11] ac gain codes 000,001,011,111, read-write
// [R12] ac gain loaded from strap at reset
// [R13] hold bit resets one, stops state machine
// [R14] hold cleared by i2c write, else automatically
// [R15] dc gain codes 011,101,111, read-write
// [R16] dc gain loaded from three-level strap
// [R17] straps captured only at reset release
// [R18] integrator starts at ac 0, dc 1
// [R19] low speed: no compensation, detect high
// [R20] reset pulse valid only if 20 us long
// [R21] new gains applied after hold returns zero
package ucc_pkg;
  localparam logic [6:0] UCC_TARGET_ADDR = 7'h2c;
  localparam logic [7:0] UCC_OFS_AC_GAIN = 8'h01;
  localparam logic [7:0] UCC_OFS_HOLD = 8'h03;
  localparam logic [7:0] UCC_OFS_DC_GAIN = 8'h0e;
  localparam int UCC_AC_LSB = 4;
  localparam int UCC_AC_MSB = 6;
  localparam int UCC_HOLD_BIT = 0;
  localparam logic [2:0] UCC_AC_L0 = 3'h0;
  localparam logic [2:0] UCC_AC_L1 = 3'h1;
  localparam logic [2:0] UCC_AC_L2 = 3'h3;
  localparam logic [2:0] UCC_AC_L3 = 3'h7;
  localparam logic [2:0] UCC_DC_40MV = 3'h3;
  localparam logic [2:0] UCC_DC_60MV = 3'h5;
  localparam logic [2:0] UCC_DC_80MV = 3'h7;
  localparam logic [7:0] UCC_HOLD_RESET = 8'h01;
  localparam int UCC_CLK_MHZ = 100;
  localparam int UCC_RST_MIN_US = 20;
  localparam int UCC_RST_MIN_CYC = UCC_RST_MIN_US * UCC_CLK_MHZ;
  localparam int UCC_I2C_KHZ = 100;
  // cycles to wait after reset release before sampling the bus lines
  localparam int UCC_BUS_SAMPLE_CYC = 16;
  // usb link speeds as seen by the analog detector
  typedef enum logic [1:0] {
    UCC_SPD_NONE = 2'b00,
    UCC_SPD_LS = 2'b01,
    UCC_SPD_FS = 2'b11,
    UCC_SPD_HS = 2'b10
  } ucc_speed_t;
  // strap three-level decode: low, mid, high
  typedef enum logic [1:0] {
    UCC_TRI_L = 2'b00,
    UCC_TRI_M = 2'b01,
    UCC_TRI_H = 2'b11
  } ucc_tri_t;
  typedef struct packed {
    logic enable;
    logic [2:0] ac_level;
    logic [2:0] dc_level;
  } ucc_comp_t;
endpackage

/* File: ucc_i2c_target.sv */
// i2c target: address match, one offset byte, byte read/write
// assumes scl/sda already synchronous to clk_sys, open-drain sda
`timescale 1ns/1ps
module ucc_i2c_target
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic enable,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {
    UCC_I_IDLE = 3'b000,
    UCC_I_ADDR = 3'b001,
    UCC_I_ACK = 3'b011,
    UCC_I_RX = 3'b010,
    UCC_I_TX = 3'b110,
    UCC_I_RACK = 3'b111
  } ucc_i2c_st_t;
  ucc_i2c_st_t state;
  logic scl_q;
  logic sda_q;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic is_read;
  logic have_ofs;
  logic ack_drive;
  logic [7:0] ofs;
  wire scl_rise = scl && !scl_q;
  wire scl_fall = !scl && scl_q;
  wire start_c = scl && scl_q && sda_q && !sda_in;
  wire stop_c = scl && scl_q && !sda_q && sda_in;
  assign rd_addr = ofs;
  always_ff @(posedge clk_sys)
  begin
    scl_q <= scl;
    sda_q <= sda_in;
  end
  always_ff @(posedge clk_sys)
  begin
    wr_stb <= 1'b0;
    if (srst || !enable || stop_c)
    begin
      state <= UCC_I_IDLE;
      sda_oe <= 1'b0;
      bitcnt <= 4'h0;
      have_ofs <= 1'b0;
      is_read <= 1'b0;
      ack_drive <= 1'b0;
      if (srst)
      begin
        ofs <= 8'h00;
        shreg <= 8'h00;
        wr_addr <= 8'h00;
        wr_data <= 8'h00;
      end
    end
    else if (start_c)
    begin
      state <= UCC_I_ADDR;
      bitcnt <= 4'h0;
      have_ofs <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        UCC_I_ADDR, UCC_I_RX:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_in};
            bitcnt <= bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == 4'h8)
          begin
            bitcnt <= 4'h0;
            if (state == UCC_I_ADDR)
            begin
              // [R7] only our address is acknowledged
              if (shreg[7:1] == ucc_pkg::UCC_TARGET_ADDR)
              begin
                is_read <= shreg[0];
                sda_oe <= 1'b1;
                state <= UCC_I_ACK;
              end
              else
                state <= UCC_I_IDLE;
            end
            else
            begin
              sda_oe <= 1'b1;
              state <= UCC_I_ACK;
              if (!have_ofs)
              begin
                ofs <= shreg;
                have_ofs <= 1'b1;
              end
              else
              begin
                wr_stb <= 1'b1;
                wr_addr <= ofs;
                wr_data <= shreg;
                ofs <= ofs + 8'h01;
              end
            end
          end
        end
        UCC_I_ACK:
        begin
          if (scl_fall)
          begin
            if (is_read)
            begin
              shreg <= rd_data;
              sda_oe <= !rd_data[7];
              bitcnt <= 4'h1;
              state <= UCC_I_TX;
            end
            else
            begin
              sda_oe <= 1'b0;
              state <= UCC_I_RX;
            end
          end
        end
        UCC_I_TX:
        begin
          if (scl_fall)
          begin
            if (bitcnt == 4'h8)
            begin
              sda_oe <= 1'b0;
              ofs <= ofs + 8'h01;
              state <= UCC_I_RACK;
            end
            else
            begin
              sda_oe <= !shreg[6];
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        UCC_I_RACK:
        begin
          if (scl_rise)
            ack_drive <= sda_in;
          else if (scl_fall)
          begin
            if (ack_drive)
              state <= UCC_I_IDLE;
            else
            begin
              shreg <= rd_data;
              sda_oe <= !rd_data[7];
              bitcnt <= 4'h1;
              state <= UCC_I_TX;
            end
          end
        end
        default: state <= UCC_I_IDLE;
      endcase
    end
  end
endmodule // ucc_i2c_target

/* File: ucc_config_ctrl.sv */
// top: reset filter, strap capture, i2c register bank, compensation control
// assumes pins synchronous to clk_sys; analog path takes comp outputs
`timescale 1ns/1ps
module ucc_config_ctrl
#(
  parameter int RST_MIN_CYC = ucc_pkg::UCC_RST_MIN_CYC,
  parameter int BUS_SAMPLE_CYC = ucc_pkg::UCC_BUS_SAMPLE_CYC
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic active_low_reset_pin_n,
  input wire logic [1:0] ac_gain_strap_pin,
  input wire logic [1:0] dc_gain_strap_pin,
  input wire logic [1:0] link_speed,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  output logic sda_out,
  output logic connection_detect_out,
  output logic comp_enable,
  output logic [2:0] comp_ac_level,
  output logic [2:0] comp_dc_level,
  output logic i2c_mode,
  output logic cfg_hold
);
  typedef enum logic [1:0] {
    UCC_M_OFF = 2'b00,
    UCC_M_SAMPLE = 2'b01,
    UCC_M_RUN = 2'b11
  } ucc_mode_t;
  ucc_mode_t mode;
  logic [$clog2(RST_MIN_CYC+1)-1:0] low_cnt;
  logic [$clog2(BUS_SAMPLE_CYC+1)-1:0] smp_cnt;
  logic shutdown;
  logic [2:0] ac_level;
  logic [2:0] dc_level;
  logic [7:0] ac_reg_q;
  logic [7:0] dc_reg_q;
  ucc_pkg::ucc_comp_t active_cfg;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic sda_oe_i;
  wire rst_low_done = (low_cnt == RST_MIN_CYC[$bits(low_cnt)-1:0]);

  // glitch filter: short low pulses do not count as reset [R20]
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      low_cnt <= '0;
      shutdown <= 1'b1;
    end
    else if (active_low_reset_pin_n)
    begin
      low_cnt <= '0;
      shutdown <= 1'b0;
    end
    else if (!rst_low_done)
      low_cnt <= low_cnt + 1'b1;
    else
      shutdown <= 1'b1; // [R3] [R20]
  end

  // mode sequencer: shutdown, sample window, run
  always_ff @(posedge clk_sys)
  begin
    if (srst || shutdown)
    begin
      mode <= UCC_M_OFF;
      smp_cnt <= '0;
      i2c_mode <= 1'b0;
    end
    else
    begin
      case (mode)
        UCC_M_OFF:
        begin
          mode <= UCC_M_SAMPLE;
          smp_cnt <= '0;
        end
        UCC_M_SAMPLE:
        begin
          if (smp_cnt == BUS_SAMPLE_CYC[$bits(smp_cnt)-1:0])
          begin
            i2c_mode <= scl_in && sda_in; // [R6]
            mode <= UCC_M_RUN;
          end
          else
            smp_cnt <= smp_cnt + 1'b1;
        end
        UCC_M_RUN: mode <= UCC_M_RUN;
        default: mode <= UCC_M_OFF;
      endcase
    end
  end

  function automatic logic [2:0] ac_decode(input logic [1:0] s);
    case (s)
      2'b00: ac_decode = ucc_pkg::UCC_AC_L0;
      2'b01: ac_decode = ucc_pkg::UCC_AC_L1;
      2'b10: ac_decode = ucc_pkg::UCC_AC_L2;
      default: ac_decode = ucc_pkg::UCC_AC_L3;
    endcase
  endfunction

  function automatic logic [2:0] dc_decode(input logic [1:0] s);
    case (s)
      ucc_pkg::UCC_TRI_L: dc_decode = ucc_pkg::UCC_DC_40MV;
      ucc_pkg::UCC_TRI_H: dc_decode = ucc_pkg::UCC_DC_80MV;
      default: dc_decode = ucc_pkg::UCC_DC_60MV;
    endcase
  endfunction

  // straps taken once on leaving shutdown, ignored after [R12] [R16] [R17]
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ac_level <= ucc_pkg::UCC_AC_L0;
      dc_level <= ucc_pkg::UCC_DC_60MV;
      ac_reg_q <= 8'h00;
      dc_reg_q <= 8'h00;
    end
    else if (mode == UCC_M_OFF && !shutdown)
    begin
      ac_level <= ac_decode(ac_gain_strap_pin); // [R12] [R17]
      dc_level <= dc_decode(dc_gain_strap_pin); // [R16] [R17]
    end
    else if (wr_stb && i2c_mode)
    begin
      // reserved bits keep whatever was written back [R11] [R15]
      if (wr_addr == ucc_pkg::UCC_OFS_AC_GAIN)
      begin
        ac_level <= wr_data[ucc_pkg::UCC_AC_MSB:ucc_pkg::UCC_AC_LSB];
        ac_reg_q <= wr_data;
      end
      if (wr_addr == ucc_pkg::UCC_OFS_DC_GAIN)
      begin
        dc_level <= wr_data[2:0];
        dc_reg_q <= wr_data;
      end
    end
  end

  // hold bit: set on reset, auto-clears without i2c [R13] [R14]
  always_ff @(posedge clk_sys)
  begin
    if (srst || shutdown || mode != UCC_M_RUN)
      cfg_hold <= ucc_pkg::UCC_HOLD_RESET[ucc_pkg::UCC_HOLD_BIT];
    else if (!i2c_mode)
      cfg_hold <= 1'b0; // [R14]
    else if (wr_stb && wr_addr == ucc_pkg::UCC_OFS_HOLD)
      cfg_hold <= wr_data[ucc_pkg::UCC_HOLD_BIT]; // [R14]
  end

  // gains reach the analog path only while the state machine runs [R21]
  always_ff @(posedge clk_sys)
  begin
    if (srst || shutdown)
    begin
      // all-zero would put an illegal dc code on the analog path
      active_cfg.enable <= 1'b0;
      active_cfg.ac_level <= ucc_pkg::UCC_AC_L0;
      active_cfg.dc_level <= ucc_pkg::UCC_DC_60MV; // [R15]
    end
    else if (!cfg_hold)
    begin
      active_cfg.enable <= 1'b1;
      active_cfg.ac_level <= ac_level; // [R21]
      active_cfg.dc_level <= dc_level; // [R21]
    end
    else
      active_cfg.enable <= 1'b0; // [R13]
  end

  always_comb
  begin
    rd_data = 8'h00;
    case (rd_addr)
      ucc_pkg::UCC_OFS_AC_GAIN:
      begin
        rd_data = ac_reg_q;
        rd_data[ucc_pkg::UCC_AC_MSB:ucc_pkg::UCC_AC_LSB] = ac_level;
      end
      ucc_pkg::UCC_OFS_HOLD: rd_data = {7'h00, cfg_hold};
      ucc_pkg::UCC_OFS_DC_GAIN:
      begin
        rd_data = dc_reg_q;
        rd_data[2:0] = dc_level;
      end
      default: rd_data = 8'h00;
    endcase
  end

  // [R5] target sampled at clk_sys, ample for a 100 kHz bus
  ucc_i2c_target u_i2c
  (
    .clk_sys(clk_sys),
    .srst(srst || shutdown),
    .enable(i2c_mode), // [R6]
    .scl(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe_i),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // outputs; data path itself is analog and never gated here [R4]
  always_ff @(posedge clk_sys)
  begin
    if (srst || shutdown)
    begin
      connection_detect_out <= 1'b0; // [R3]
      comp_enable <= 1'b0; // [R3]
      comp_ac_level <= ucc_pkg::UCC_AC_L0;
      comp_dc_level <= ucc_pkg::UCC_DC_60MV;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      sda_oe <= sda_oe_i;
      sda_out <= 1'b0;
      connection_detect_out <=
        (link_speed != ucc_pkg::UCC_SPD_NONE); // [R1] [R2] [R19]
      comp_enable <= active_cfg.enable &&
        (link_speed == ucc_pkg::UCC_SPD_HS); // [R1] [R2] [R19]
      comp_ac_level <= active_cfg.ac_level; // [R2]
      comp_dc_level <= active_cfg.dc_level; // [R2]
    end
  end
endmodule // ucc_config_ctrl

/* File: ucc_config_ctrl_properties.sv */
// checker: port properties of the config/control top
// bound to ucc_config_ctrl; watches its ports only
`timescale 1ns/1ps
module ucc_config_ctrl_properties
#(
  parameter int RST_MIN_CYC = 2000,
  parameter int BUS_SAMPLE_CYC = 16
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic active_low_reset_pin_n,
  input wire logic [1:0] ac_gain_strap_pin,
  input wire logic [1:0] dc_gain_strap_pin,
  input wire logic [1:0] link_speed,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic sda_out,
  input wire logic connection_detect_out,
  input wire logic comp_enable,
  input wire logic [2:0] comp_ac_level,
  input wire logic [2:0] comp_dc_level,
  input wire logic i2c_mode,
  input wire logic cfg_hold
);
  int lo_n;
  int hi_n;
  // saturating run lengths of the reset pin, low and high
  always_ff @(posedge clk_sys)
  begin
    if (srst || active_low_reset_pin_n)
      lo_n <= 0;
    else if (lo_n < RST_MIN_CYC + 9)
      lo_n <= lo_n + 1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst || !active_low_reset_pin_n)
      hi_n <= 0;
    else if (hi_n < BUS_SAMPLE_CYC + 9)
      hi_n <= hi_n + 1;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_detect_needs_link: assert property (
    connection_detect_out |-> $past(link_speed) != 2'h0)
    else $error("detect high without a link");
  a_detect_off_idle: assert property (
    link_speed == 2'h0 |=> !connection_detect_out)
    else $error("detect high with no link");
  a_comp_only_hs: assert property (
    comp_enable |-> $past(link_speed) == 2'h2 && !$past(cfg_hold, 2))
    else $error("compensation outside high speed run");
  a_shutdown_quiet: assert property (
    lo_n > RST_MIN_CYC + 2 |-> !connection_detect_out && !comp_enable
      && cfg_hold)
    else $error("activity during shutdown");
  a_hold_reset_one: assert property (
    $fell(srst) |-> cfg_hold && !i2c_mode)
    else $error("hold bit not set after reset");
  a_hold_autoclear: assert property (
    hi_n == BUS_SAMPLE_CYC + 6 && !i2c_mode |-> ##[0:40] !cfg_hold)
    else $error("hold bit not cleared outside bus mode");
  a_mode_needs_lines: assert property (
    $rose(i2c_mode) |-> $past(scl_in) && $past(sda_in))
    else $error("bus mode without both lines high");
  a_ack_needs_mode: assert property (
    sda_oe |-> i2c_mode && !sda_out)
    else $error("data line pulled outside bus mode");
  a_sda_stable_high: assert property (
    $changed(sda_oe) |-> !$past(scl_in))
    else $error("data line moved while clock high");
  a_gain_after_hold: assert property (
    $changed(comp_ac_level) && active_low_reset_pin_n
      |-> !$past(cfg_hold, 2))
    else $error("gain applied while hold set");
  a_levels_legal: assert property (
    comp_ac_level inside {3'h0, 3'h1, 3'h3, 3'h7}
      && comp_dc_level inside {3'h3, 3'h5, 3'h7})
    else $error("illegal gain code applied");
  c_hs_comp: cover property (comp_enable);
  c_ack: cover property ($rose(sda_oe));
  c_shutdown: cover property (lo_n > RST_MIN_CYC + 2);
  c_mode: cover property ($rose(i2c_mode));
endmodule // ucc_config_ctrl_properties

bind ucc_config_ctrl ucc_config_ctrl_properties #(
  .RST_MIN_CYC(RST_MIN_CYC),
  .BUS_SAMPLE_CYC(BUS_SAMPLE_CYC)
) ucc_config_ctrl_properties_inst (.*);

/* File: ucc_i2c_ctrl_model.sv */
// i2c bus controller model with pull-ups on both lines
// target pulls sda via sda_oe; released lines read high
`timescale 1ns/1ps
module ucc_i2c_ctrl_model
#(
  // faster than 100 kHz to keep the run short; target is edge driven
  parameter int Q = 10
)
(
  input wire logic clk_sys,
  input wire logic sda_oe,
  output logic scl_line,
  output logic sda_line
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  assign scl_line = !scl_low;
  assign sda_line = !(sda_low || sda_oe);
  task tick;
    repeat (Q) @(posedge clk_sys);
  endtask
  task park(input logic lo);
    @(posedge clk_sys);
    scl_low <= lo;
    sda_low <= lo;
  endtask
  task bit_x(input logic b, output logic r);
    sda_low <= !b;
    tick;
    scl_low <= 1'b0;
    tick;
    r = sda_line;
    tick;
    scl_low <= 1'b1;
    tick;
  endtask
  task byte_x(input [7:0] d, output [7:0] r, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], n);
      r[i] = n;
    end
    bit_x(1'b1, n);
    ack = !n;
  endtask
  task start_c;
    @(posedge clk_sys);
    sda_low <= 1'b1;
    tick;
    scl_low <= 1'b1;
    tick;
  endtask
  task stop_c;
    sda_low <= 1'b1;
    tick;
    scl_low <= 1'b0;
    tick;
    sda_low <= 1'b0;
    tick;
  endtask
  task wr(input [6:0] a, input [7:0] o, input [7:0] d, output logic ok);
    logic k1, k2, k3;
    logic [7:0] r;
    start_c;
    byte_x({a, 1'b0}, r, k1);
    byte_x(o, r, k2);
    byte_x(d, r, k3);
    stop_c;
    ok = k1 && k2 && k3;
  endtask
  // offset set by a write frame, then a fresh read frame ends in nack
  task rd(input [6:0] a, input [7:0] o, output [7:0] d, output logic ok);
    logic k1, k2, k3, k4;
    logic [7:0] r;
    start_c;
    byte_x({a, 1'b0}, r, k1);
    byte_x(o, r, k2);
    stop_c;
    start_c;
    byte_x({a, 1'b1}, r, k3);
    byte_x(8'hff, d, k4);
    stop_c;
    ok = k1 && k2 && k3;
  endtask
endmodule // ucc_i2c_ctrl_model

/* File: tb_ucc_config_ctrl.sv */
// testbench: straps, pin reset, register access, link speeds
// drives the top directly; controller model sits on the bus
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("MISMATCH %0t got %h exp %h", $time, g, e); \
    end \
  end
module tb_ucc_config_ctrl;
  localparam int RMIN = 20;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic active_low_reset_pin_n = 1'b1;
  logic [1:0] ac_gain_strap_pin = 2'h0;
  logic [1:0] dc_gain_strap_pin = 2'h0;
  logic [1:0] link_speed = 2'h0;
  logic scl_in, sda_in, sda_oe, sda_out, connection_detect_out;
  logic comp_enable, i2c_mode, cfg_hold, ok;
  logic [2:0] comp_ac_level, comp_dc_level;
  logic [7:0] rd_v;
  int bad_count = 0;
  int tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  ucc_config_ctrl #(.RST_MIN_CYC(RMIN)) ucc_config_ctrl_inst (
    .clk_sys, .srst, .active_low_reset_pin_n, .ac_gain_strap_pin,
    .dc_gain_strap_pin, .link_speed, .scl_in, .sda_in, .sda_oe,
    .sda_out, .connection_detect_out, .comp_enable, .comp_ac_level,
    .comp_dc_level, .i2c_mode, .cfg_hold);
  ucc_i2c_ctrl_model ucc_i2c_ctrl_model_inst (.clk_sys, .sda_oe,
    .scl_line(scl_in), .sda_line(sda_in));
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task pin_reset(input int n);
    @(posedge clk_sys);
    active_low_reset_pin_n <= 1'b0;
    cyc(n);
    active_low_reset_pin_n <= 1'b1;
    cyc(60);
  endtask
  task w(input [7:0] o, input [7:0] d);
    ucc_i2c_ctrl_model_inst.wr(ucc_pkg::UCC_TARGET_ADDR, o, d, ok);
    `CHK(ok, 1'b1)
  endtask
  task r(input [7:0] o, input [7:0] e);
    ucc_i2c_ctrl_model_inst.rd(ucc_pkg::UCC_TARGET_ADDR, o, rd_v, ok);
    `CHK({ok, rd_v}, {1'b1, e})
  endtask
  task t_straps;
    logic [1:0] dcs [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    logic [2:0] dce [4] = '{3'h3, 3'h7, 3'h5, 3'h5};
    logic [2:0] ace [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic [1:0] spd [3] = '{2'h3, 2'h1, 2'h0};
    ucc_i2c_ctrl_model_inst.park(1'b1);
    link_speed <= 2'h2;
    for (int i = 0; i < 4; i++)
    begin
      ac_gain_strap_pin <= 2'(i);
      dc_gain_strap_pin <= dcs[i];
      pin_reset(RMIN + 4);
      `CHK({i2c_mode, cfg_hold, comp_enable}, 3'b001)
      `CHK(comp_ac_level, ace[i])
      `CHK(comp_dc_level, dce[i])
    end
    ac_gain_strap_pin <= 2'h0;
    dc_gain_strap_pin <= 2'h0;
    cyc(40);
    `CHK({comp_ac_level, comp_dc_level}, 6'o75)
    for (int i = 0; i < 3; i++)
    begin
      link_speed <= spd[i];
      cyc(3);
      `CHK({connection_detect_out, comp_enable}, {i < 2, 1'b0})
    end
    $display("t_straps done");
  endtask
  task t_i2c;
    link_speed <= 2'h2;
    ac_gain_strap_pin <= 2'h3;
    dc_gain_strap_pin <= 2'h1;
    ucc_i2c_ctrl_model_inst.park(1'b0);
    pin_reset(RMIN + 4);
    `CHK({i2c_mode, cfg_hold, comp_enable}, 3'b110)
    r(8'h01, 8'h70);
    r(8'h0e, 8'h05);
    r(8'h03, 8'h01);
    r(8'h05, 8'h00);
    w(8'h01, 8'h10);
    w(8'h0e, 8'h07);
    ucc_i2c_ctrl_model_inst.wr(7'h2d, 8'h01, 8'h70, ok);
    `CHK(ok, 1'b0)
    r(8'h01, 8'h10);
    `CHK({comp_enable, comp_ac_level}, 4'h0)
    w(8'h03, 8'h01);
    w(8'h03, 8'h00);
    cyc(3);
    `CHK({cfg_hold, comp_enable}, 2'b01)
    `CHK({comp_ac_level, comp_dc_level}, 6'o17)
    $display("t_i2c done");
  endtask
  task t_shutdown;
    @(posedge clk_sys);
    active_low_reset_pin_n <= 1'b0;
    cyc(RMIN - 4);
    active_low_reset_pin_n <= 1'b1;
    cyc(3);
    `CHK({connection_detect_out, comp_enable}, 2'b11)
    active_low_reset_pin_n <= 1'b0;
    cyc(RMIN + 4);
    `CHK({connection_detect_out, comp_enable, cfg_hold}, 3'b001)
    active_low_reset_pin_n <= 1'b1;
    cyc(60);
    `CHK({i2c_mode, connection_detect_out}, 2'b11)
    $display("t_shutdown done");
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    cyc(8);
    srst <= 1'b0;
    cyc(40);
    t_straps;
    t_i2c;
    t_shutdown;
    final_report;
  end
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    $display("MISMATCH %0t run too long", $time);
    final_report;
  end
endmodule // tb_ucc_config_ctrl
